// ===== hw/bidir_fifo_pkg.sv
package bidir_fifo_pkg;

  // ******************************************************
  // Sizes
  // ******************************************************
  localparam int unsigned DATA_W  = 18;
  localparam int unsigned ADDR_W  = 9;
  localparam int unsigned LEVEL_W = 10;
  localparam logic [LEVEL_W-1:0] FIFO_DEPTH = 10'h200;

  // ******************************************************
  // Reset values
  // ******************************************************
  localparam logic [ADDR_W-1:0]  OFFSET_RESET = 9'h008;
  localparam logic [ADDR_W:0]    PTR_RESET    = 10'h000;
  localparam logic [DATA_W-1:0]  DATA_RESET   = 18'h00000;

  // ******************************************************
  // Port A resource addresses
  // ******************************************************
  localparam logic [2:0] RES_FIFO    = 3'h0;
  localparam logic [2:0] RES_BYPASS  = 3'h1;
  localparam logic [2:0] RES_AB_AE   = 3'h4;
  localparam logic [2:0] RES_AB_AF   = 3'h5;
  localparam logic [2:0] RES_BA_AE   = 3'h6;
  localparam logic [2:0] RES_BA_AF   = 3'h7;

  // ******************************************************
  // Types
  // ******************************************************
  typedef enum logic [1:0] {
    BYP_IDLE   = 2'b00,
    BYP_ACTIVE = 2'b01,
    BYP_DRAIN  = 2'b10
  } bypass_e;

  typedef struct packed {
    logic              clock;
    logic              chipSelectN;
    logic [2:0]        resourceAddress;
    logic              readSelect;
    logic              enableN;
    logic [DATA_W-1:0] data;
  } port_a_pins_s;

  typedef struct packed {
    logic              clock;
    logic              directionSelect;
    logic              transferEnableN;
    logic              outputEnableN;
    logic [DATA_W-1:0] data;
  } port_b_pins_s;

  typedef struct packed {
    logic abEmptyN;
    logic abAlmostEmptyN;
    logic abAlmostFullN;
    logic abFullN;
    logic baEmptyN;
    logic baAlmostEmptyN;
    logic baAlmostFullN;
    logic baFullN;
  } flags_s;

  localparam flags_s FLAGS_RESET = '{abEmptyN: 1'b0, abAlmostEmptyN: 1'b0,
                                     abAlmostFullN: 1'b1, abFullN: 1'b1,
                                     baEmptyN: 1'b0, baAlmostEmptyN: 1'b0,
                                     baAlmostFullN: 1'b1, baFullN: 1'b1};

endpackage : bidir_fifo_pkg

// ===== hw/two_entry_buffer.sv
`timescale 1ns/100ps
`default_nettype none

module two_entry_buffer
  import bidir_fifo_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              reset,
  // Fill side
  input  wire logic              inValid,
  output logic                   inReady,
  input  wire logic [DATA_W-1:0] inData,
  // Drain side
  output logic                   outValid,
  input  wire logic              outReady,
  output logic [DATA_W-1:0]      outData,
  // Occupancy
  output logic [1:0]             count
);

  // ******************************************************
  // Storage
  // ******************************************************
  logic [DATA_W-1:0] slot_q [2];
  logic              rdIdx_q;
  logic              wrIdx_q;
  logic [1:0]        count_q;
  wire               push = inValid && inReady;
  wire               pop  = outValid && outReady;

  assign inReady  = (count_q != 2'h2);
  assign outValid = (count_q != 2'h0);
  assign outData  = slot_q[rdIdx_q];
  assign count    = count_q;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      rdIdx_q <= 1'b0;
      wrIdx_q <= 1'b0;
      count_q <= 2'h0;
    end
    else
    begin
      if (push)
        wrIdx_q <= ~wrIdx_q;
      if (pop)
        rdIdx_q <= ~rdIdx_q;
      count_q <= count_q + {1'b0, push} - {1'b0, pop};
    end
  end

  // Data slots carry no reset; only the index and count matter
  always_ff @(posedge clk)
  begin
    if (push)
      slot_q[wrIdx_q] <= inData;
  end

endmodule : two_entry_buffer

`default_nettype wire

// ===== hw/bidir_fifo_port_b.sv
// What this block does
// - Write select with enable low captures port B data on port B clock; enable high ignores it.
// - A sampled write select turns the port B bus off even with output enable low.
// - Read select with enable low loads the next stored word into the output register.
// - In read direction, output enable low drives the bus, high leaves it off.
// - Read with enable high holds the output register and the read pointer.
// - Address 000 only: an enabled read takes the next FIFO word and advances; a read at 1XX does not.
// - Address 001: port B reads take bypass data instead of FIFO memory.
// - A disabled read never advances the read pointer, whatever the address.
// - Almost-empty uses the empty offset n, almost-full the full offset m, depth D.
// - First word after empty reaches the read side one or two read clocks later.
// - Chip select high during bypass returns to FIFO mode on the next port A clock.
// - Bypass completion raises the bypass indicator, returns bypass state to idle and clears the pending flag; the bypass word register keeps its value.
// - After port A leaves bypass, port B gets two more bypass cycles (the active edge, then the drain edge), then is forced back.
// - A-to-B almost-empty updates on the port B clock, may slip one edge.
// - A-to-B almost-full updates on the port A clock, may slip one edge.
// - B-to-A almost-empty updates on the port A clock, may slip one edge.
// - B-to-A almost-full updates on the port B clock, may slip one edge.
// - Almost-empty asserts low once the level falls to n words.
// - Almost-full asserts low once the level (for A-to-B, memory words only, not the output buffer) reaches D minus m words.
// - Reset sets all four flag offsets to 8.
// - The bypass indicator rises on a port B clock after the last bypass transfer.
// - Empty and full are fixed; every flag is active low.
`timescale 1ns/100ps
`default_nettype none

module bidir_fifo_port_b
  import bidir_fifo_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              reset,
  // Port A pins
  input  wire port_a_pins_s      portAPins,
  output logic [DATA_W-1:0]      portADataOut,
  // Port B pins
  input  wire port_b_pins_s      portBPins,
  output logic [DATA_W-1:0]      portBDataOut,
  output logic                   portBDataOe,
  // Status pins
  output flags_s                 flags,
  output logic                   portBBypassIndicatorN
);

  // ******************************************************
  // Pin synchronisers
  // ******************************************************
  // Clock pins are sampled like data; the third stage only feeds edge detection
  port_a_pins_s aMeta_q;
  port_a_pins_s aSync_q;
  logic         aClkOld_q;
  port_b_pins_s bMeta_q;
  port_b_pins_s bSync_q;
  logic         bClkOld_q;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      aMeta_q   <= '0;
      aSync_q   <= '0;
      aClkOld_q <= 1'b0;
      bMeta_q   <= '0;
      bSync_q   <= '0;
      bClkOld_q <= 1'b0;
    end
    else
    begin
      aMeta_q   <= portAPins;
      aSync_q   <= aMeta_q;
      aClkOld_q <= aSync_q.clock;
      bMeta_q   <= portBPins;
      bSync_q   <= bMeta_q;
      bClkOld_q <= bSync_q.clock;
    end
  end

  wire aEdge = aSync_q.clock && !aClkOld_q;
  wire bEdge = bSync_q.clock && !bClkOld_q;

  // ******************************************************
  // Port A decode
  // ******************************************************
  wire aSelected  = aEdge && !aSync_q.chipSelectN;
  wire aEnabled   = aSelected && !aSync_q.enableN;
  wire aWrite     = aEnabled && !aSync_q.readSelect;
  wire aRead      = aEnabled && aSync_q.readSelect;
  wire aAtFifo    = (aSync_q.resourceAddress == RES_FIFO);
  wire aAtBypass  = (aSync_q.resourceAddress == RES_BYPASS);
  wire aAtOffset  = aSync_q.resourceAddress[2];

  // ******************************************************
  // Port B decode
  // ******************************************************
  wire bEnabled   = bEdge && !bSync_q.transferEnableN;
  wire bWrite     = bEnabled && !bSync_q.directionSelect;
  wire bRead      = bEnabled && bSync_q.directionSelect;

  // ******************************************************
  // Flag offsets
  // ******************************************************
  logic [ADDR_W-1:0] abEmptyOffset_q;
  logic [ADDR_W-1:0] abFullOffset_q;
  logic [ADDR_W-1:0] baEmptyOffset_q;
  logic [ADDR_W-1:0] baFullOffset_q;
  wire  [ADDR_W-1:0] offsetIn = aSync_q.data[ADDR_W-1:0];

  // Upper data bits are don't-care; bit 8 is the caller's to keep clear on small parts
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      abEmptyOffset_q <= OFFSET_RESET;
      abFullOffset_q  <= OFFSET_RESET;
      baEmptyOffset_q <= OFFSET_RESET;
      baFullOffset_q  <= OFFSET_RESET;
    end
    else if (aWrite && aAtOffset)
    begin
      if (aSync_q.resourceAddress == RES_AB_AE)
        abEmptyOffset_q <= offsetIn;
      if (aSync_q.resourceAddress == RES_AB_AF)
        abFullOffset_q <= offsetIn;
      if (aSync_q.resourceAddress == RES_BA_AE)
        baEmptyOffset_q <= offsetIn;
      if (aSync_q.resourceAddress == RES_BA_AF)
        baFullOffset_q <= offsetIn;
    end
  end

  // ******************************************************
  // Bypass control
  // ******************************************************
  logic              aBypassMode_q;
  bypass_e           bypassState_q;
  bypass_e           bypassState_d;
  logic [DATA_W-1:0] bypassWord_q;
  logic              bypassFull_q;

  wire bBypassPath = (bypassState_q != BYP_IDLE);
  wire bBypassRead = bRead && bBypassPath;
  wire aBypassLoad = aWrite && aAtBypass;

  always_comb
  begin
    bypassState_d = bypassState_q;
    unique case (bypassState_q)
      BYP_IDLE:
        if (aBypassMode_q)
          bypassState_d = BYP_ACTIVE;
      BYP_ACTIVE:
        if (!aBypassMode_q)
          bypassState_d = BYP_DRAIN;
      BYP_DRAIN:
        bypassState_d = BYP_IDLE;
      default:
        bypassState_d = BYP_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      aBypassMode_q <= 1'b0;
    else if (aEdge)
      aBypassMode_q <= !aSync_q.chipSelectN && aAtBypass;
  end

  // Hand-back clears the pending word: a late port B read simply misses it
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      bypassState_q         <= BYP_IDLE;
      portBBypassIndicatorN <= 1'b1;
    end
    else if (bEdge)
    begin
      bypassState_q         <= bypassState_d;
      portBBypassIndicatorN <= (bypassState_d == BYP_IDLE);
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      bypassWord_q <= DATA_RESET;
      bypassFull_q <= 1'b0;
    end
    else if (aBypassLoad)
    begin
      bypassWord_q <= aSync_q.data;
      bypassFull_q <= 1'b1;
    end
    else if (bEdge && (bBypassRead || bypassState_q == BYP_DRAIN))
      bypassFull_q <= 1'b0;
  end

  // ******************************************************
  // A-to-B memory
  // ******************************************************
  logic [DATA_W-1:0] abMem [512];
  logic [ADDR_W:0]   abWrPtr_q;
  logic [ADDR_W:0]   abRdPtr_q;
  wire  [ADDR_W:0]   abMemLevel = abWrPtr_q - abRdPtr_q;
  wire               abMemFull  = (abMemLevel == FIFO_DEPTH);
  wire               abPush     = aWrite && aAtFifo && !abMemFull;
  wire               abFetch;
  wire               abFetchReady;
  wire               abBufValid;
  wire [DATA_W-1:0]  abBufData;
  wire [1:0]         abBufCount;
  // A FIFO read must not steal the bypass word's slot in the output register
  wire               abPop      = bRead && !bBypassPath && abBufValid;

  // Prefetch only while the buffer has room, so a slow port B stalls the memory side
  assign abFetch = (abMemLevel != PTR_RESET) && abFetchReady;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      abWrPtr_q <= PTR_RESET;
      abRdPtr_q <= PTR_RESET;
    end
    else
    begin
      if (abPush)
        abWrPtr_q <= abWrPtr_q + 10'h001;
      if (abFetch)
        abRdPtr_q <= abRdPtr_q + 10'h001;
    end
  end

  always_ff @(posedge clk)
  begin
    if (abPush)
      abMem[abWrPtr_q[ADDR_W-1:0]] <= aSync_q.data;
  end

  // Word written on one port A edge is fetched within a clk and ready for the next B edge
  two_entry_buffer abBuffer (
    .clk      (clk),
    .reset    (reset),
    .inValid  (abFetch),
    .inReady  (abFetchReady),
    .inData   (abMem[abRdPtr_q[ADDR_W-1:0]]),
    .outValid (abBufValid),
    .outReady (abPop),
    .outData  (abBufData),
    .count    (abBufCount)
  );

  // ******************************************************
  // B-to-A memory
  // ******************************************************
  logic [DATA_W-1:0] baMem [512];
  logic [ADDR_W:0]   baWrPtr_q;
  logic [ADDR_W:0]   baRdPtr_q;
  wire  [ADDR_W:0]   baLevel    = baWrPtr_q - baRdPtr_q;
  wire               baPush     = bWrite && !bBypassPath && (baLevel != FIFO_DEPTH);
  wire               baPop      = aRead && aAtFifo && (baLevel != PTR_RESET);
  wire               baBypassIn = bWrite && bBypassPath;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      baWrPtr_q <= PTR_RESET;
      baRdPtr_q <= PTR_RESET;
    end
    else
    begin
      if (baPush)
        baWrPtr_q <= baWrPtr_q + 10'h001;
      if (baPop)
        baRdPtr_q <= baRdPtr_q + 10'h001;
    end
  end

  always_ff @(posedge clk)
  begin
    if (baPush)
      baMem[baWrPtr_q[ADDR_W-1:0]] <= bSync_q.data;
  end

  // ******************************************************
  // Output registers
  // ******************************************************
  wire               portBLoad = abPop || (bBypassRead && bypassFull_q);
  wire [DATA_W-1:0]  portBNext = bBypassPath ? bypassWord_q : abBufData;
  logic              bReadDir_q;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      portBDataOut <= DATA_RESET;
      portADataOut <= DATA_RESET;
      bReadDir_q   <= 1'b0;
      portBDataOe  <= 1'b0;
    end
    else
    begin
      if (portBLoad)
        portBDataOut <= portBNext;
      if (baPop)
        portADataOut <= baMem[baRdPtr_q[ADDR_W-1:0]];
      else if (baBypassIn)
        portADataOut <= bSync_q.data;
      if (bEdge)
        bReadDir_q <= bSync_q.directionSelect;
      portBDataOe <= bReadDir_q && !bSync_q.outputEnableN;
    end
  end

  // ******************************************************
  // Flags
  // ******************************************************
  // Each flag moves only on its own port's edge; a crossing edge may land one edge late
  wire [LEVEL_W-1:0] abLevel = abMemLevel + {8'h00, abBufCount};
  wire [LEVEL_W-1:0] abAeTh  = {1'b0, abEmptyOffset_q};
  wire [LEVEL_W-1:0] abAfTh  = FIFO_DEPTH - {1'b0, abFullOffset_q};
  wire [LEVEL_W-1:0] baAeTh  = {1'b0, baEmptyOffset_q};
  wire [LEVEL_W-1:0] baAfTh  = FIFO_DEPTH - {1'b0, baFullOffset_q};
  // Flags see the level after this edge's own transfer, so their own port's edge moves them
  wire [LEVEL_W-1:0] abRdLevel = abLevel - {9'h000, abPop};
  wire [LEVEL_W-1:0] abWrLevel = abMemLevel + {9'h000, abPush};
  wire [LEVEL_W-1:0] baWrLevel = baLevel + {9'h000, baPush};
  wire [LEVEL_W-1:0] baRdLevel = baLevel - {9'h000, baPop};

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      flags <= FLAGS_RESET;
    else
    begin
      if (bEdge)
      begin
        flags.abEmptyN       <= (abRdLevel != PTR_RESET);
        flags.abAlmostEmptyN <= (abRdLevel > abAeTh);
        flags.baAlmostFullN  <= (baWrLevel < baAfTh);
        flags.baFullN        <= (baWrLevel != FIFO_DEPTH);
      end
      if (aEdge)
      begin
        flags.abAlmostFullN  <= (abWrLevel < abAfTh);
        flags.abFullN        <= (abWrLevel != FIFO_DEPTH);
        flags.baEmptyN       <= (baRdLevel != PTR_RESET);
        flags.baAlmostEmptyN <= (baRdLevel > baAeTh);
      end
    end
  end

endmodule : bidir_fifo_port_b

`default_nettype wire

// ===== verif/bidir_fifo_port_b_properties.sv
`timescale 1ns/100ps
`default_nettype none

module bidir_fifo_port_b_properties
  import bidir_fifo_pkg::*;
(
  // Clock and reset
  input wire logic              clk,
  input wire logic              reset,
  // Port A
  input wire port_a_pins_s      portAPins,
  input wire logic [DATA_W-1:0] portADataOut,
  // Port B
  input wire port_b_pins_s      portBPins,
  input wire logic [DATA_W-1:0] portBDataOut,
  input wire logic              portBDataOe,
  // Status
  input wire flags_s            flags,
  input wire logic              portBBypassIndicatorN
);
  // ****************************************************
  // Pin sampling, mirrors the two-stage synchroniser
  // ****************************************************
  port_b_pins_s bSync1_q;
  port_b_pins_s bSync2_q;
  logic         bClk_q;
  logic         aSync1_q;
  logic         aSync2_q;
  logic         aClk_q;
  logic         aEvt;
  logic         bEvt;

  // No reset needed: port clocks stay low in reset, so no false edge
  always_ff @(posedge clk)
  begin
    bSync1_q <= portBPins;
    bSync2_q <= bSync1_q;
    bClk_q   <= bSync2_q.clock;
    aSync1_q <= portAPins.clock;
    aSync2_q <= aSync1_q;
    aClk_q   <= aSync2_q;
  end

  assign bEvt = bSync2_q.clock & ~bClk_q;
  assign aEvt = aSync2_q & ~aClk_q;

  // ****************************************************
  // Properties
  // ****************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence bReadOff;
    bEvt && bSync2_q.directionSelect && bSync2_q.transferEnableN;
  endsequence
  sequence bWriteSeen;
    bEvt && !bSync2_q.directionSelect;
  endsequence
  sequence bReadDrive;
    bEvt && bSync2_q.directionSelect && !bSync2_q.outputEnableN;
  endsequence

  reset_values_a: assert property ($fell(reset) |-> flags == FLAGS_RESET
    && portBBypassIndicatorN && !portBDataOe) else $error("reset state wrong");
  read_hold_a: assert property (bReadOff |=> $stable(portBDataOut) [*2])
    else $error("port B output moved on disabled read");
  write_hiz_a: assert property (bWriteSeen |-> ##[1:2] !portBDataOe ##1 !portBDataOe)
    else $error("port B bus driven after write select");
  oe_drive_a: assert property (bReadDrive |-> ##[1:2] portBDataOe)
    else $error("port B bus not driven");
  oe_release_a: assert property ($rose(portBPins.outputEnableN) |-> ##[1:4] !portBDataOe)
    else $error("port B bus not released");
  ab_empty_clock_a: assert property ($changed(flags.abAlmostEmptyN)
    |-> $past(bEvt) || $past(bEvt, 2)) else $error("ab almost empty off port B clock");
  ab_full_clock_a: assert property ($changed(flags.abAlmostFullN)
    |-> $past(aEvt) || $past(aEvt, 2)) else $error("ab almost full off port A clock");
  ba_empty_clock_a: assert property ($changed(flags.baAlmostEmptyN)
    |-> $past(aEvt) || $past(aEvt, 2)) else $error("ba almost empty off port A clock");
  ba_full_clock_a: assert property ($changed(flags.baAlmostFullN)
    |-> $past(bEvt) || $past(bEvt, 2)) else $error("ba almost full off port B clock");
  bypass_edge_a: assert property ($changed(portBBypassIndicatorN)
    |-> $past(bEvt) || $past(bEvt, 2)) else $error("bypass indicator off port B clock");
endmodule : bidir_fifo_port_b_properties

bind bidir_fifo_port_b bidir_fifo_port_b_properties u_bidir_fifo_port_b_properties (
  .clk(clk), .reset(reset), .portAPins(portAPins), .portADataOut(portADataOut),
  .portBPins(portBPins), .portBDataOut(portBDataOut), .portBDataOe(portBDataOe),
  .flags(flags), .portBBypassIndicatorN(portBBypassIndicatorN)
);

`default_nettype wire

// ===== verif/port_b_master.sv
`timescale 1ns/100ps
`default_nettype none

module port_b_master
  import bidir_fifo_pkg::*;
(
  // Clock
  input  wire logic          clk,
  // Device drive state
  input  wire logic          deviceDrives,
  // Pins towards the device
  output var  port_b_pins_s  pins
);
  logic drivenLast;

  initial
  begin
    pins = '{clock: 1'b0, directionSelect: 1'b1, transferEnableN: 1'b1,
             outputEnableN: 1'b1, data: DATA_RESET};
    drivenLast = 1'b0;
  end

  // One port clock: 3 clk high, 7 clk low, results land before return
  task automatic pulse(input logic dir, input logic enN, input logic oeN,
                       input logic [DATA_W-1:0] word);
    @(negedge clk);
    pins.directionSelect = dir;
    pins.transferEnableN = enN;
    pins.outputEnableN   = oeN;
    pins.data            = dir ? ~pins.data : word;
    repeat (2) @(negedge clk);
    pins.clock = 1'b1;
    repeat (3) @(negedge clk);
    pins.clock = 1'b0;
    repeat (4) @(negedge clk);
    drivenLast = deviceDrives;
  endtask : pulse

  // Released lines show the inverse of the last value, never a stale word
  task automatic transfer(input logic dir, input logic enN, input logic oeN,
                          input logic [DATA_W-1:0] word);
    if (!dir && !enN && drivenLast)
    begin
      pulse(1'b0, 1'b1, 1'b1, word);
    end
    pulse(dir, enN, oeN, word);
  endtask : transfer
endmodule : port_b_master

`default_nettype wire

// ===== verif/tb.sv
`timescale 1ns/100ps
`default_nettype none

module tb
  import bidir_fifo_pkg::*;
();
  logic              clk;
  logic              reset;
  port_a_pins_s      aPins;
  port_b_pins_s      masterPins;
  port_b_pins_s      bPins;
  logic [DATA_W-1:0] aDataOut;
  logic [DATA_W-1:0] bDataOut;
  logic              bDataOe;
  flags_s            flags;
  logic              bypassN;
  int                bad_count;
  int                num_checks;

  // Device output wins the shared bus while it drives
  assign bPins = bDataOe ? port_b_pins_s'({masterPins[$bits(port_b_pins_s)-1:DATA_W], bDataOut})
                         : masterPins;

  bidir_fifo_port_b u_bidir_fifo_port_b (
    .clk(clk), .reset(reset), .portAPins(aPins), .portADataOut(aDataOut),
    .portBPins(bPins), .portBDataOut(bDataOut), .portBDataOe(bDataOe),
    .flags(flags), .portBBypassIndicatorN(bypassN)
  );

  port_b_master u_port_b_master (.clk(clk), .deviceDrives(bDataOe), .pins(masterPins));

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ****************************************************
  // Helpers
  // ****************************************************
  task automatic checkWord(input string what, input logic [DATA_W-1:0] expv,
                           input logic [DATA_W-1:0] got);
    num_checks++;
    if (got !== expv)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, expv, got);
    end
  endtask : checkWord

  task automatic checkBit(input string what, input logic expv, input logic got);
    num_checks++;
    if (got !== expv)
    begin
      bad_count++;
      $display("ERROR %s expected %b seen %b", what, expv, got);
    end
  endtask : checkBit

  task automatic aCycle(input logic csN, input logic [2:0] addr, input logic rdSel,
                        input logic enN, input logic [DATA_W-1:0] word);
    @(negedge clk);
    aPins.chipSelectN     = csN;
    aPins.resourceAddress = addr;
    aPins.readSelect      = rdSel;
    aPins.enableN         = enN;
    aPins.data            = (!rdSel && !enN) ? word : ~aPins.data;
    repeat (2) @(negedge clk);
    aPins.clock = 1'b1;
    repeat (3) @(negedge clk);
    aPins.clock = 1'b0;
    repeat (4) @(negedge clk);
  endtask : aCycle

  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
    begin
      $display("== PASSED ==");
    end
    else
    begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : complete_run

  // ****************************************************
  // Scenarios
  // ****************************************************
  task automatic resetState();
    checkWord("flags", DATA_W'(FLAGS_RESET), DATA_W'(flags));
    checkBit("output enable", 1'b0, bDataOe);
    checkBit("bypass indicator", 1'b1, bypassN);
    checkWord("port B data", DATA_RESET, bDataOut);
  endtask : resetState

  task automatic fifoRead();
    for (int i = 0; i < 9; i++)
    begin
      aCycle(1'b0, RES_FIFO, 1'b0, 1'b0, 18'h00010 + DATA_W'(i));
    end
    u_port_b_master.transfer(1'b1, 1'b1, 1'b1, 18'h00000);
    checkBit("ab empty", 1'b1, flags.abEmptyN);
    checkBit("ab almost empty", 1'b1, flags.abAlmostEmptyN);
    u_port_b_master.transfer(1'b1, 1'b0, 1'b1, 18'h00000);
    checkWord("first word", 18'h00010, bDataOut);
    checkBit("output enable", 1'b0, bDataOe);
    checkBit("ab almost empty", 1'b0, flags.abAlmostEmptyN);
    u_port_b_master.transfer(1'b1, 1'b1, 1'b0, 18'h00000);
    checkWord("held word", 18'h00010, bDataOut);
    aPins.resourceAddress = RES_AB_AE;
    u_port_b_master.transfer(1'b1, 1'b0, 1'b0, 18'h00000);
    checkWord("second word", 18'h00011, bDataOut);
    checkBit("output enable", 1'b1, bDataOe);
  endtask : fifoRead

  task automatic writeDir();
    u_port_b_master.transfer(1'b0, 1'b0, 1'b0, 18'h2AAAA);
    checkBit("output enable", 1'b0, bDataOe);
    u_port_b_master.transfer(1'b0, 1'b1, 1'b0, 18'h00003);
    aCycle(1'b0, RES_FIFO, 1'b1, 1'b0, 18'h00000);
    checkWord("port A word", 18'h2AAAA, aDataOut);
    checkBit("ba empty", 1'b0, flags.baEmptyN);
    aCycle(1'b0, RES_FIFO, 1'b1, 1'b0, 18'h00000);
    checkWord("port A held", 18'h2AAAA, aDataOut);
  endtask : writeDir

  task automatic flagOffsets();
    aCycle(1'b0, RES_BA_AF, 1'b0, 1'b0, 18'h001FE);
    aCycle(1'b0, RES_BA_AE, 1'b0, 1'b0, 18'h00001);
    u_port_b_master.transfer(1'b0, 1'b0, 1'b1, 18'h00005);
    checkBit("ba almost full", 1'b1, flags.baAlmostFullN);
    u_port_b_master.transfer(1'b0, 1'b0, 1'b1, 18'h00006);
    checkBit("ba almost full", 1'b0, flags.baAlmostFullN);
    aCycle(1'b1, RES_FIFO, 1'b1, 1'b1, 18'h00000);
    checkBit("ba almost empty", 1'b1, flags.baAlmostEmptyN);
    checkBit("ba empty", 1'b1, flags.baEmptyN);
    aCycle(1'b0, RES_FIFO, 1'b1, 1'b0, 18'h00000);
    checkWord("port A word", 18'h00005, aDataOut);
    checkBit("ba almost empty", 1'b0, flags.baAlmostEmptyN);
    aCycle(1'b0, RES_AB_AF, 1'b0, 1'b0, 18'h001FF);
    aCycle(1'b1, RES_FIFO, 1'b1, 1'b1, 18'h00000);
    checkBit("ab almost full", 1'b0, flags.abAlmostFullN);
  endtask : flagOffsets

  task automatic bypassPath();
    aCycle(1'b0, RES_BYPASS, 1'b0, 1'b1, 18'h00000);
    u_port_b_master.transfer(1'b1, 1'b1, 1'b1, 18'h00000);
    checkBit("bypass indicator", 1'b0, bypassN);
    aCycle(1'b0, RES_BYPASS, 1'b0, 1'b0, 18'h15A5A);
    u_port_b_master.transfer(1'b1, 1'b0, 1'b1, 18'h00000);
    checkWord("bypass word", 18'h15A5A, bDataOut);
    u_port_b_master.transfer(1'b0, 1'b0, 1'b1, 18'h0A5A5);
    checkWord("bypass to A", 18'h0A5A5, aDataOut);
    aCycle(1'b1, RES_BYPASS, 1'b0, 1'b1, 18'h00000);
    u_port_b_master.transfer(1'b1, 1'b1, 1'b1, 18'h00000);
    u_port_b_master.transfer(1'b1, 1'b1, 1'b1, 18'h00000);
    checkBit("bypass indicator", 1'b1, bypassN);
    u_port_b_master.transfer(1'b1, 1'b0, 1'b1, 18'h00000);
    checkWord("fifo after bypass", 18'h00012, bDataOut);
  endtask : bypassPath

  // ****************************************************
  // Main sequence and watchdog
  // ****************************************************
  initial
  begin
    aPins = '{clock: 1'b0, chipSelectN: 1'b1, resourceAddress: RES_FIFO,
              readSelect: 1'b1, enableN: 1'b1, data: DATA_RESET};
    bad_count  = 0;
    num_checks = 0;
    reset      = 1'b1;
    repeat (3) @(negedge clk);
    reset = 1'b0;
    repeat (2) @(negedge clk);
    resetState();
    fifoRead();
    writeDir();
    flagOffsets();
    bypassPath();
    complete_run();
  end

  // About 35 port cycles of 10 clk each; ample margin
  initial
  begin
    repeat (3000) @(posedge clk);
    bad_count++;
    complete_run();
  end
endmodule : tb

`default_nettype wire
